/* File: src/aab_ack_sync.sv */
// acknowledge synchroniser for the bus master.
// assumes the acknowledge pin is asynchronous to clk_sys and active low.
`timescale 1ns/10ps

module aab_ack_sync
(
  input  wire logic clk_sys,       // system clock
  input  wire logic reset,         // synchronous reset, active high
  input  wire logic ackPinN,       // raw acknowledge pin, active low
  output logic      ackSync        // synchronised acknowledge, active high
);

  logic ackMeta;

  // ------------------------------------------------------------
  // two-stage capture
  // ------------------------------------------------------------
  // first stage on the falling edge so that an acknowledge set up before the
  // falling edge of one clock is seen at the next rising edge; costs half a
  // period of settling time instead of a full one
  always_ff @(negedge clk_sys)
  begin
    if (reset)
      ackMeta <= 1'b0;
    else
      ackMeta <= ~ackPinN;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ackSync <= 1'b0;
    else
      ackSync <= ackMeta;
  end

endmodule

/* File: src/aab_bus_master.sv */
// external bus master for slaves that end each transfer with an asynchronous
// acknowledge: single cycles, bursts and burst-inhibited sequences.
// assumes aligned operands, one request at a time, and a slave that answers.
`timescale 1ns/10ps
`include "aab_consts.svh"

module aab_bus_master
(
  input  wire logic                    clk_sys,            // system clock, 10 MHz
  input  wire logic                    reset,              // synchronous reset, active high
  input  wire logic                    reqValid,           // request offered
  output logic                         reqReady,           // request taken this edge
  input  wire logic [`AAB_ADDR_W-1:0]  reqAddr,            // operand address
  input  wire logic                    reqWrite,           // 1 write, 0 read
  input  wire logic [1:0]              reqOpSize,          // operand size, size-code encoding
  input  wire logic [1:0]              reqPortSize,        // port width, size-code encoding
  input  wire logic                    regionBurstEnable,  // burst enable of selected region
  input  wire logic                    reqCode,            // 1 code fetch, 0 data access
  input  wire logic                    reqSuper,           // 1 supervisor, 0 user
  input  wire logic [1:0]              reqKind,            // access type for transferKind
  input  wire logic [`AAB_LINE_W-1:0]  reqWriteData,       // write operand, right-justified
  output logic                         rspValid,           // operand done, one-cycle pulse
  output logic [`AAB_LINE_W-1:0]       rspData,            // read operand, right-justified
  output logic [`AAB_ADDR_W-1:0]       addrOut,            // address bus
  output logic                         transferStartN,     // cycle start strobe, active low
  output logic                         readWrite,          // 1 read, 0 write
  output logic [1:0]                   transferSizeCode,   // transfer size code
  output logic [1:0]                   transferKind,       // transfer kind
  output logic                         accessAttr,         // code/data then privilege
  input  wire logic [`AAB_BUS_W-1:0]   dataIn,             // data bus, pin level
  output logic [`AAB_BUS_W-1:0]        dataOut,            // data bus, driven value
  output logic                         dataOeN,            // data bus enable, low drives
  input  wire logic                    asyncTransferAckN   // slave acknowledge, active low
);

  aab_pkg::aab_regs_type r;
  aab_pkg::aab_regs_type next_r;
  logic                  ackSync;
  logic [`AAB_BUS_W-1:0] dataInSync1;
  logic [`AAB_BUS_W-1:0] dataInSync2;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [2:0] sizeLog(input logic [1:0] code);
    logic [2:0] res;
    res = `AAB_LOG_LONG;
    unique case (code)
      `AAB_SIZE_BYTE: res = `AAB_LOG_BYTE;
      `AAB_SIZE_WORD: res = `AAB_LOG_WORD;
      `AAB_SIZE_LONG: res = `AAB_LOG_LONG;
      `AAB_SIZE_LINE: res = `AAB_LOG_LINE;
    endcase
    return res;
  endfunction

  // operand placed at the top of the shifter so each beat takes the high part
  function automatic logic [`AAB_LINE_W-1:0] leftJustify(input logic [`AAB_LINE_W-1:0] d,
                                                         input logic [2:0] opLog);
    logic [`AAB_LINE_W-1:0] res;
    res = d;
    unique case (opLog)
      `AAB_LOG_BYTE: res = {d[7:0], 120'h0};
      `AAB_LOG_WORD: res = {d[15:0], 112'h0};
      `AAB_LOG_LONG: res = {d[31:0], 96'h0};
      default:       res = d;
    endcase
    return res;
  endfunction

  // narrow ports use the high lanes of the bus
  function automatic logic [`AAB_BUS_W-1:0] beatOut(input logic [`AAB_LINE_W-1:0] sh,
                                                    input logic [2:0] xl);
    logic [`AAB_BUS_W-1:0] res;
    res = sh[127:96];
    unique case (xl)
      `AAB_LOG_BYTE: res = {sh[127:120], 24'h0};
      `AAB_LOG_WORD: res = {sh[127:112], 16'h0};
      default:       res = sh[127:96];
    endcase
    return res;
  endfunction

  function automatic logic [`AAB_LINE_W-1:0] shiftOut(input logic [`AAB_LINE_W-1:0] sh,
                                                      input logic [2:0] xl);
    logic [`AAB_LINE_W-1:0] res;
    res = {sh[95:0], 32'h0};
    unique case (xl)
      `AAB_LOG_BYTE: res = {sh[119:0], 8'h0};
      `AAB_LOG_WORD: res = {sh[111:0], 16'h0};
      default:       res = {sh[95:0], 32'h0};
    endcase
    return res;
  endfunction

  function automatic logic [`AAB_LINE_W-1:0] shiftIn(input logic [`AAB_LINE_W-1:0] acc,
                                                     input logic [`AAB_BUS_W-1:0] d,
                                                     input logic [2:0] xl);
    logic [`AAB_LINE_W-1:0] res;
    res = {acc[95:0], d};
    unique case (xl)
      `AAB_LOG_BYTE: res = {acc[119:0], d[31:24]};
      `AAB_LOG_WORD: res = {acc[111:0], d[31:16]};
      default:       res = {acc[95:0], d};
    endcase
    return res;
  endfunction

  // offset wraps inside the line so a line burst stays in its 16 bytes
  function automatic logic [`AAB_ADDR_W-1:0] beatAddr(input logic [`AAB_ADDR_W-1:0] base,
                                                      input logic [`AAB_OFS_W-1:0] ofs);
    logic [`AAB_OFS_W-1:0] low;
    low = base[`AAB_OFS_W-1:0] + ofs;
    return {base[`AAB_ADDR_W-1:`AAB_OFS_W], low};
  endfunction

  // ------------------------------------------------------------
  // acknowledge and data capture
  // ------------------------------------------------------------
  aab_ack_sync u_ack_sync
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .ackPinN (asyncTransferAckN),
    .ackSync (ackSync)
  );

  // data pins pass two flops, lined up with the acknowledge path
  always_ff @(negedge clk_sys)
  begin
    dataInSync1 <= dataIn;
  end

  always_ff @(posedge clk_sys)
  begin
    dataInSync2 <= dataInSync1;
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  assign reqReady = (r.state == aab_pkg::ST_IDLE);

  always_comb
  begin
    logic [2:0]            opLog;
    logic [2:0]            portLog;
    logic [2:0]            xl;
    logic [`AAB_OFS_W-1:0] nextOfs;
    opLog   = sizeLog(reqOpSize);
    portLog = sizeLog(reqPortSize);
    xl      = (opLog > portLog) ? portLog : opLog;
    nextOfs = r.offset + `AAB_OFS_W'(5'h1 << r.xferLog);
    next_r  = r;
    next_r.rspValid = 1'b0;
    unique case (r.state)
      aab_pkg::ST_IDLE:
      begin
        if (reqValid)
        begin
          next_r.state      = aab_pkg::ST_START;
          next_r.addrBase   = reqAddr;
          next_r.offset     = '0;
          next_r.xferLog    = xl;
          next_r.beatsLeft  = `AAB_BEATS_W'(5'h1 << (opLog - xl));
          next_r.burst      = regionBurstEnable && (opLog > portLog);
          next_r.codeAccess = reqCode;
          next_r.superUser  = reqSuper;
          next_r.writeShift = leftJustify(reqWriteData, opLog);
          next_r.readAccum  = '0;
          next_r.addrOut    = reqAddr;
          next_r.transferStartN = 1'b0;
          next_r.readWrite  = reqWrite ? `AAB_RW_WRITE : `AAB_RW_READ;
          next_r.transferKind = reqKind;
          next_r.accessAttr = reqCode ? `AAB_ATTR_CODE : `AAB_ATTR_DATA;
          // inhibited: port code when operand is wider, so line code never shows
          if (opLog > portLog && !regionBurstEnable)
            next_r.transferSizeCode = reqPortSize;
          else
            next_r.transferSizeCode = reqOpSize;
        end
      end
      aab_pkg::ST_START:
      begin
        next_r.state          = aab_pkg::ST_DATA;
        next_r.transferStartN = 1'b1;
        next_r.accessAttr     = r.superUser ? `AAB_ATTR_SUPER : `AAB_ATTR_USER;
        if (r.readWrite == `AAB_RW_WRITE)
        begin
          next_r.dataOut = beatOut(r.writeShift, r.xferLog);
          next_r.dataOeN = 1'b0;
        end
      end
      aab_pkg::ST_DATA:
        next_r.state = aab_pkg::ST_SAMPLE;
      aab_pkg::ST_SAMPLE:
      begin
        // no acknowledge means another wait state with everything held
        if (ackSync)
        begin
          next_r.readAccum  = shiftIn(r.readAccum, dataInSync2, r.xferLog);
          next_r.writeShift = shiftOut(r.writeShift, r.xferLog);
          next_r.beatsLeft  = r.beatsLeft - `AAB_BEATS_W'(1);
          next_r.offset     = nextOfs;
          if (r.beatsLeft == `AAB_BEATS_W'(1))
          begin
            next_r.state    = aab_pkg::ST_IDLE;
            next_r.dataOeN  = 1'b1;
            next_r.rspValid = 1'b1;
            next_r.rspData  = shiftIn(r.readAccum, dataInSync2, r.xferLog);
          end
          else if (r.burst)
          begin
            // next beat starts at this edge; its acknowledge is sampled one clock later at the earliest
            next_r.addrOut = beatAddr(r.addrBase, nextOfs);
            next_r.dataOut = beatOut(shiftOut(r.writeShift, r.xferLog), r.xferLog);
          end
          else
          begin
            next_r.state          = aab_pkg::ST_START;
            next_r.addrOut        = beatAddr(r.addrBase, nextOfs);
            next_r.transferStartN = 1'b0;
            next_r.dataOeN        = 1'b1;
            next_r.accessAttr     = r.codeAccess ? `AAB_ATTR_CODE : `AAB_ATTR_DATA;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      r                  <= '0;
      r.state            <= aab_pkg::ST_IDLE;
      r.transferStartN   <= 1'b1;
      r.readWrite        <= `AAB_RW_READ;
      r.dataOeN          <= 1'b1;
    end
    else
      r <= next_r;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rspValid         = r.rspValid;
  assign rspData          = r.rspData;
  assign addrOut          = r.addrOut;
  assign transferStartN   = r.transferStartN;
  assign readWrite        = r.readWrite;
  assign transferSizeCode = r.transferSizeCode;
  assign transferKind     = r.transferKind;
  assign accessAttr       = r.accessAttr;
  assign dataOut          = r.dataOut;
  assign dataOeN          = r.dataOeN;

endmodule

/* File: src/aab_consts.svh */
// constant header for the asynchronous acknowledge bus master.
// assumes inclusion by bare name from the package and the master module.
`ifndef AAB_CONSTS_SVH
`define AAB_CONSTS_SVH

`define AAB_SIZE_LONG   2'h0
`define AAB_SIZE_BYTE   2'h1
`define AAB_SIZE_WORD   2'h2
`define AAB_SIZE_LINE   2'h3

`define AAB_LOG_BYTE    3'h0
`define AAB_LOG_WORD    3'h1
`define AAB_LOG_LONG    3'h2
`define AAB_LOG_LINE    3'h4

`define AAB_ATTR_CODE   1'b1
`define AAB_ATTR_DATA   1'b0
`define AAB_ATTR_SUPER  1'b1
`define AAB_ATTR_USER   1'b0

`define AAB_RW_READ     1'b1
`define AAB_RW_WRITE    1'b0

`define AAB_ADDR_W      28
`define AAB_OFS_W       4
`define AAB_BEATS_W     5
`define AAB_LINE_W      128
`define AAB_BUS_W       32

`endif

/* File: src/aab_pkg.sv */
// types for the asynchronous acknowledge bus master.
// assumes aab_consts.svh sits on the include path.
`include "aab_consts.svh"

package aab_pkg;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_START  = 2'b01,
    ST_DATA   = 2'b10,
    ST_SAMPLE = 2'b11
  } aab_state_type;

  typedef struct packed
  {
    aab_state_type                 state;
    logic [`AAB_ADDR_W-1:0]        addrBase;
    logic [`AAB_OFS_W-1:0]         offset;
    logic [`AAB_BEATS_W-1:0]       beatsLeft;
    logic [2:0]                    xferLog;
    logic                          burst;
    logic                          codeAccess;
    logic                          superUser;
    logic [`AAB_LINE_W-1:0]        writeShift;
    logic [`AAB_LINE_W-1:0]        readAccum;
    logic [`AAB_ADDR_W-1:0]        addrOut;
    logic                          transferStartN;
    logic                          readWrite;
    logic [1:0]                    transferSizeCode;
    logic [1:0]                    transferKind;
    logic                          accessAttr;
    logic [`AAB_BUS_W-1:0]         dataOut;
    logic                          dataOeN;
    logic                          rspValid;
    logic [`AAB_LINE_W-1:0]        rspData;
  } aab_regs_type;

endpackage

/* File: testbench/aab_bus_master_checker.sv */
// port assertions for the asynchronous acknowledge bus master.
// assumes the bench holds request fields until the operand completes.
`timescale 1ns/10ps
`include "aab_consts.svh"

module aab_bus_master_checker
(
  input wire logic                   clk_sys,           // clock
  input wire logic                   reset,             // sync reset
  input wire logic                   reqReady,          // idle
  input wire logic                   regionBurstEnable, // burst bit
  input wire logic [1:0]             reqPortSize,       // port width
  input wire logic                   reqCode,           // code fetch
  input wire logic                   reqSuper,          // supervisor
  input wire logic [1:0]             reqKind,           // access type
  input wire logic                   rspValid,          // done pulse
  input wire logic [`AAB_ADDR_W-1:0] addrOut,           // address bus
  input wire logic                   transferStartN,    // start strobe
  input wire logic                   readWrite,         // direction
  input wire logic [1:0]             transferSizeCode,  // size code
  input wire logic [1:0]             transferKind,      // kind
  input wire logic                   accessAttr,        // attribute
  input wire logic                   dataOeN,           // bus enable
  input wire logic                   asyncTransferAckN  // acknowledge
);
  logic [1:0] lwPrev;

  // ----------
  // assertions
  // ----------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // slice kept apart so the step check compares against the last cycle
  always_ff @(posedge clk_sys)
    lwPrev <= addrOut[3:2];

  chk_start_one: assert property ($fell(transferStartN) |=> transferStartN)
    else $error("start strobe held past first clock");
  chk_first_attr: assert property (!transferStartN |-> accessAttr == reqCode && transferKind == reqKind)
    else $error("first clock attribute or kind wrong");
  chk_priv_attr: assert property ($rose(transferStartN) && !reqReady |-> accessAttr == reqSuper)
    else $error("second clock privilege wrong");
  chk_write_drive: assert property (!transferStartN && !readWrite |=> !dataOeN)
    else $error("write data not driven in second clock");
  chk_dir_hold: assert property (!reqReady && $past(!reqReady) |-> $stable(readWrite))
    else $error("direction changed inside an operand");
  chk_read_float: assert property (readWrite |-> dataOeN)
    else $error("data bus driven during a read");
  chk_bus_release: assert property (rspValid && !readWrite |-> dataOeN)
    else $error("data bus held after last write beat");
  chk_ack_needed: assert property (rspValid |-> !$past(asyncTransferAckN, 2))
    else $error("operand ended without acknowledge");
  chk_no_line: assert property (!transferStartN && !regionBurstEnable |-> transferSizeCode != `AAB_SIZE_LINE)
    else $error("line size shown with bursts inhibited");
  chk_line_step: assert property ($changed(addrOut) && transferStartN && transferSizeCode == `AAB_SIZE_LINE
    && reqPortSize == `AAB_SIZE_LONG |-> addrOut[3:2] == lwPrev + 2'h1)
    else $error("line beat address did not step one longword");

  cover property (!transferStartN && transferSizeCode == `AAB_SIZE_LINE && !readWrite);
  cover property ($rose(rspValid) && $past(asyncTransferAckN, 3));
  cover property (!transferStartN && $past(!reqReady));
endmodule

bind aab_bus_master aab_bus_master_checker u_aab_bus_master_checker
(
  .clk_sys(clk_sys), .reset(reset), .reqReady(reqReady), .regionBurstEnable(regionBurstEnable),
  .reqPortSize(reqPortSize), .reqCode(reqCode), .reqSuper(reqSuper), .reqKind(reqKind),
  .rspValid(rspValid), .addrOut(addrOut), .transferStartN(transferStartN),
  .readWrite(readWrite), .transferSizeCode(transferSizeCode), .transferKind(transferKind),
  .accessAttr(accessAttr), .dataOeN(dataOeN), .asyncTransferAckN(asyncTransferAckN)
);

/* File: testbench/aab_bus_master_tb.sv */
// self-checking bench for the bus master facing the slave model.
// assumes design, checker and slave model are compiled before it.
`timescale 1ns/10ps
`include "aab_consts.svh"

module aab_bus_master_tb;
  logic                   clk_sys = 1'b0;
  logic                   reset = 1'b1;
  logic                   reqValid = 1'b0;
  logic                   reqWrite = 1'b0;
  logic                   regionBurstEnable = 1'b0;
  logic                   reqCode = 1'b0;
  logic                   reqSuper = 1'b0;
  logic                   clr = 1'b0;
  logic [1:0]             reqOpSize = 2'h0;
  logic [1:0]             reqPortSize = 2'h0;
  logic [1:0]             reqKind = 2'h0;
  logic [3:0]             waits = 4'h0;
  logic [`AAB_ADDR_W-1:0] reqAddr = 28'h0;
  logic [`AAB_LINE_W-1:0] reqWriteData = 128'h0;
  logic                   reqReady, rspValid, transferStartN, readWrite, accessAttr, dataOeN, ackN;
  logic [1:0]             transferSizeCode, transferKind;
  logic [`AAB_ADDR_W-1:0] addrOut;
  logic [`AAB_LINE_W-1:0] rspData;
  logic [31:0]            dataOut, dataPin;
  logic [1:0]             stSize [32];
  logic [`AAB_ADDR_W-1:0] stAddr [32];
  int                     nStarts = 0;
  int                     errors = 0;
  int                     nChecks = 0;

  aab_bus_master u_aab_bus_master (.clk_sys(clk_sys), .reset(reset), .reqValid(reqValid),
    .reqReady(reqReady), .reqAddr(reqAddr), .reqWrite(reqWrite), .reqOpSize(reqOpSize),
    .reqPortSize(reqPortSize), .regionBurstEnable(regionBurstEnable), .reqCode(reqCode),
    .reqSuper(reqSuper), .reqKind(reqKind), .reqWriteData(reqWriteData), .rspValid(rspValid),
    .rspData(rspData), .addrOut(addrOut), .transferStartN(transferStartN), .readWrite(readWrite),
    .transferSizeCode(transferSizeCode), .transferKind(transferKind), .accessAttr(accessAttr),
    .dataIn(dataPin), .dataOut(dataOut), .dataOeN(dataOeN), .asyncTransferAckN(ackN));
  aab_slave_model u_aab_slave_model (.clk_sys(clk_sys), .reset(reset), .clr(clr),
    .waits(waits), .portSize(reqPortSize), .startN(transferStartN), .readWrite(readWrite),
    .sizeCode(transferSizeCode), .dataOut(dataOut), .dataOeN(dataOeN), .ackN(ackN),
    .dataPin(dataPin));

  always #50 clk_sys = ~clk_sys;

  // -------------------------
  // cycle-start monitor
  // -------------------------
  always @(posedge clk_sys)
  begin
    if (!reset && transferStartN === 1'b0 && nStarts < 32)
    begin
      stSize[nStarts] = transferSizeCode;
      stAddr[nStarts] = addrOut;
      nStarts++;
    end
  end

  function automatic int nb(input logic [1:0] c);
    return (c == 2'h0) ? 4 : (c == 2'h3) ? 16 : int'(c);
  endfunction

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one operand end to end; csk packs code, supervisor and kind
  task automatic xfer(input logic [27:0] a, input logic wr, input logic [1:0] op,
                      input logic [1:0] port, input logic be, input logic [3:0] csk,
                      input logic [127:0] wd, input logic [3:0] w);
    int           cyc;
    int           lb;
    int           n;
    logic         inh;
    logic [127:0] e;
    logic [127:0] m;
    lb = (nb(op) < nb(port)) ? nb(op) : nb(port);
    n = nb(op) / lb;
    inh = !be && n > 1;
    e = 128'h0;
    m = (128'h1 << (8 * lb)) - 128'h1;
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqAddr <= a;
    reqWrite <= wr;
    reqOpSize <= op;
    reqPortSize <= port;
    regionBurstEnable <= be;
    {reqCode, reqSuper, reqKind} <= csk;
    reqWriteData <= wd;
    waits <= w;
    clr <= 1'b1;
    nStarts = 0;
    @(posedge clk_sys);
    reqValid <= 1'b0;
    clr <= 1'b0;
    cyc = 0;
    while (rspValid !== 1'b1 && cyc < 300)
    begin
      @(negedge clk_sys);
      cyc++;
    end
    if (cyc >= 300)
    begin
      errors++;
      test_done();
    end
    check(cyc, inh ? 4 + w + (n - 1) * (3 + w) : 4 + w + (n - 1) * (1 + w));
    check(nStarts, inh ? n : 1);
    for (int k = 0; k < nStarts; k++)
    begin
      check(stSize[k], inh ? port : op);
      check(stAddr[k], a + k * lb);
    end
    for (int k = 0; k < n; k++)
      if (wr)
        check(u_aab_slave_model.wrLog[k] >> (32 - 8 * lb), (wd >> (8 * lb * (n - 1 - k))) & m);
      else
        e = (e << (8 * lb)) | ((32'h8090a0b0 ^ {4{4'h0, 4'(k)}}) >> (32 - 8 * lb));
    if (!wr)
      check(rspData, e);
  endtask

  task automatic t_line_write_burst();
    xfer(28'h0000120, 1'b1, `AAB_SIZE_LINE, `AAB_SIZE_LONG, 1'b1, 4'h1,
         128'h00112233445566778899aabbccddeeff, 4'h1);
    $display("line write burst done");
  endtask

  task automatic t_long_read_burst();
    xfer(28'h0000344, 1'b0, `AAB_SIZE_LONG, `AAB_SIZE_WORD, 1'b1, 4'h6, 128'h0, 4'h2);
    $display("long read burst done");
  endtask

  task automatic t_word_read_inhibit();
    xfer(28'h0000402, 1'b0, `AAB_SIZE_WORD, `AAB_SIZE_BYTE, 1'b0, 4'h8, 128'h0, 4'h0);
    $display("word read inhibited done");
  endtask

  task automatic t_line_write_inhibit();
    xfer(28'h0000510, 1'b1, `AAB_SIZE_LINE, `AAB_SIZE_WORD, 1'b0, 4'h7,
         128'hfedcba98765432100123456789abcdef, 4'h1);
    $display("line write inhibited done");
  endtask

  task automatic t_size_codes();
    logic [1:0] ops [4] = '{`AAB_SIZE_BYTE, `AAB_SIZE_WORD, `AAB_SIZE_LONG, `AAB_SIZE_LINE};
    for (int i = 0; i < 4; i++)
      xfer(28'h0000600 + 28'(16 * i), 1'b0, ops[i], `AAB_SIZE_LONG, 1'b1, {2'(i), 2'(i)},
           128'h0, 4'(i));
    $display("size codes done");
  endtask

  task automatic t_line_read_byte_port();
    xfer(28'h0000700, 1'b0, `AAB_SIZE_LINE, `AAB_SIZE_BYTE, 1'b1, 4'h2, 128'h0, 4'h0);
    $display("sixteen beat burst done");
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    t_line_write_burst();
    t_long_read_burst();
    t_word_read_inhibit();
    t_line_write_inhibit();
    t_size_codes();
    t_line_read_byte_port();
    test_done();
  end
endmodule

/* File: testbench/aab_slave_model.sv */
// slave on the far side of the bus: acknowledges each beat after a set
// number of wait states. assumes it shares the master's clock.
`timescale 1ns/10ps

module aab_slave_model
(
  input  wire logic        clk_sys,   // system clock
  input  wire logic        reset,     // sync reset
  input  wire logic        clr,       // restart beat numbering
  input  wire logic [3:0]  waits,     // wait states per beat
  input  wire logic [1:0]  portSize,  // port width code
  input  wire logic        startN,    // cycle start strobe
  input  wire logic        readWrite, // 1 read
  input  wire logic [1:0]  sizeCode,  // transfer size code
  input  wire logic [31:0] dataOut,   // master data
  input  wire logic        dataOeN,   // master drives when low
  output logic             ackN,      // acknowledge pin
  output logic [31:0]      dataPin    // data bus level
);
  logic [31:0] slvData = 32'h0;
  logic [31:0] wrLog [16];
  logic        ackWas;
  logic        ackDly = 1'b0;
  int          wIdx = 0;
  int          left = 0;
  int          wcnt = 0;
  int          idx = 0;

  initial ackN = 1'b1;
  assign dataPin = (dataOeN === 1'b0) ? dataOut : slvData;

  function automatic int nb(input logic [1:0] c);
    return (c == 2'h0) ? 4 : (c == 2'h3) ? 16 : int'(c);
  endfunction

  always @(posedge clk_sys)
  begin
    ackWas = (ackN == 1'b0);
    if (clr)
    begin
      idx = 0;
      wIdx = 0;
    end
    // write data is latched at the edge where the master samples the synced acknowledge
    if (ackDly && !readWrite)
    begin
      wrLog[wIdx[3:0]] <= dataOut;
      wIdx++;
    end
    ackDly <= ackWas;
    if (ackWas)
      idx++;
    // read data stands only while the acknowledge pin is low, then toggles
    slvData <= ~slvData;
    if (!reset && !startN)
    begin
      left = (nb(sizeCode) > nb(portSize)) ? nb(sizeCode) / nb(portSize) : 1;
      wcnt = waits;
    end
    if (left > 0 && wcnt == 0)
    begin
      ackN <= 1'b0;
      if (readWrite)
        slvData <= 32'h8090a0b0 ^ {4{4'h0, idx[3:0]}};
      left--;
      wcnt = waits;
    end
    else
    begin
      ackN <= 1'b1;
      if (left > 0)
        wcnt--;
    end
  end
endmodule
